// File: bench/mrsx_exec_sva.sv
`timescale 1ns/1ps
module mrsx_exec_chk
  import mrsx_pkg::*;
(
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  input wire logic                         instr_valid,
  input wire logic                         instr_ready,
  input wire logic [mrsx_pkg::INSTR_W-1:0] instr,
  input wire logic [mrsx_pkg::DATA_W-1:0]  file_rdata,
  input wire logic [mrsx_pkg::PC_W-1:0]    stack_top,
  input wire logic                         stack_pop,
  input wire logic                         file_we,
  input wire logic [mrsx_pkg::FADDR_W-1:0] file_waddr,
  input wire logic [mrsx_pkg::DATA_W-1:0]  file_wdata,
  input wire logic                         option_we,
  input wire logic [mrsx_pkg::DATA_W-1:0]  option_value,
  input wire logic [mrsx_pkg::DATA_W-1:0]  acc_value,
  input wire logic [mrsx_pkg::PC_W-1:0]    pc,
  input wire logic                         zero_flag,
  input wire logic                         timeout_status_bit,
  input wire logic                         powerdown_status_bit,
  input wire logic                         pin_change_wake_flag,
  input wire logic                         watchdog_counter_clear,
  input wire logic                         sleep_mode
);
  wire logic tk  = instr_valid && instr_ready;
  wire logic ret = tk && instr[11:8] == 4'h8;
  wire logic slp = tk && instr == 12'h003;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_spaced: assert property (instr_ready |=> !instr_ready) else $error("ready twice");
  a_pc_step: assert property (tk && !ret |=> pc == PC_W'($past(pc) + 1))
    else $error("pc did not step by one");
  a_ret_load: assert property (ret |=> stack_pop && pc == $past(stack_top)
    && acc_value == $past(instr[7:0]) && $stable(zero_flag)) else $error("return load wrong");
  a_ret_two: assert property (ret |=> !instr_ready [*3]) else $error("return too short");
  a_sleep_enter: assert property (slp |=> watchdog_counter_clear && timeout_status_bit
    && !powerdown_status_bit && sleep_mode) else $error("sleep entry wrong");
  a_sleep_flag: assert property (slp |=> $stable(pin_change_wake_flag))
    else $error("wake flag changed");
  a_sleep_halt: assert property (sleep_mode |-> !instr_ready) else $error("ready asleep");
  a_store_acc: assert property (tk && instr[11:5] == 7'h01 |=> file_we
    && file_waddr == $past(instr[4:0]) && file_wdata == $past(acc_value) && $stable(zero_flag))
    else $error("store wrong");
  a_lit_load: assert property (tk && instr[11:8] == 4'hc |=>
    acc_value == $past(instr[7:0]) && $stable(zero_flag)) else $error("literal wrong");
  a_or_acc: assert property (tk && instr[11:5] == 7'h08 |=>
    acc_value == ($past(acc_value) | $past(file_rdata)) && zero_flag == (acc_value == 8'h00))
    else $error("or into acc wrong");
  a_option_copy: assert property (tk && instr == 12'h002 |=> option_we
    && option_value == $past(acc_value)) else $error("option wrong");
  a_nop_quiet: assert property (tk && instr == 12'h000 |=> !file_we && !option_we
    && $stable(acc_value) && $stable(zero_flag)) else $error("nop changed state");
  a_move_dest: assert property (tk && instr[11:6] == 6'h08 |=> file_we == $past(instr[5])
    && zero_flag == ($past(file_rdata) == 8'h00)) else $error("move wrong");
  c_ret: cover property (ret);
  c_sleep: cover property (slp);
  c_store: cover property (tk && instr[11:5] == 7'h01);
  c_or_file: cover property (tk && instr[11:5] == 7'h09);
endmodule

bind mrsx_exec mrsx_exec_chk u_chk (.core_clk, .rst_n, .instr_valid, .instr_ready, .instr,
  .file_rdata, .stack_top, .stack_pop, .file_we, .file_waddr, .file_wdata, .option_we,
  .option_value, .acc_value, .pc, .zero_flag, .timeout_status_bit, .powerdown_status_bit,
  .pin_change_wake_flag, .watchdog_counter_clear, .sleep_mode);

// File: bench/mrsx_exec_tb_top.sv
`timescale 1ns/1ps
module mrsx_exec_tb_top;
  import mrsx_pkg::*;
  localparam int D = 2;
  logic        core_clk, rst_n, hsel, hwrite, instr_valid;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] instr;
  logic [7:0]  file_rdata;
  logic [8:0]  stack_top, pc_e;
  wire logic   hready, hreadyout, hresp, instr_ready, stack_pop, file_we, option_we, zero_flag;
  wire logic   timeout_status_bit, powerdown_status_bit, pin_change_wake_flag;
  wire logic   watchdog_counter_clear, sleep_mode;
  wire logic [31:0] hrdata;
  wire logic [4:0]  file_waddr;
  wire logic [7:0]  file_wdata, option_value, acc_value;
  wire logic [8:0]  pc;
  int          n_fail, n_tests;
  assign hready = hreadyout;

  mrsx_exec #(.CYC_DIV_P(D)) u_dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .instr_valid, .instr_ready, .instr,
    .file_rdata, .stack_top, .stack_pop, .file_we, .file_waddr, .file_wdata, .option_we,
    .option_value, .acc_value, .pc, .zero_flag, .timeout_status_bit, .powerdown_status_bit,
    .pin_change_wake_flag, .watchdog_counter_clear, .sleep_mode);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task hang();
    n_fail++;
    $display("ERROR %0t wait limit reached", $time);
    results();
  endtask

  // Samples hready at each rising edge until the slave answers.
  task wait_hr();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (hready === 1'b1) break;
    end
    if (i == 50) hang();
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_hr();
    htrans <= 2'b00;
    hwdata <= d;
    wait_hr();
    rd = hrdata;
    chk(hresp, 1'b0, "hresp okay");
    hsel <= 1'b0;
  endtask

  task exe(input logic [11:0] w, input logic [7:0] fr, input logic [8:0] st = 9'h000);
    int i;
    @(posedge core_clk);
    instr <= w;
    file_rdata <= fr;
    stack_top <= st;
    instr_valid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge core_clk);
      if (instr_ready === 1'b1) break;
    end
    if (i == 50) hang();
    @(posedge core_clk);
    instr_valid <= 1'b0;
    pc_e = (w[11:8] == 4'h8) ? st : pc_e + 9'h1;
    #1;
    chk(pc, pc_e, "pc");
  endtask

  // Counts cycles from an accepted instruction to the next ready.
  task gap(input int n);
    int i;
    for (i = 1; i < 50; i++) begin
      @(negedge core_clk);
      if (instr_ready === 1'b1) break;
    end
    chk(i, n, "ready spacing");
  endtask

  task t_reset();
    chk(acc_value, 8'h00, "acc reset");
    chk({timeout_status_bit, powerdown_status_bit}, 2'b11, "status reset");
    ahb(1'b0, REG_OPTION, 32'h0);
    chk(rd, 32'hff, "option read");
    ahb(1'b1, 8'h40, 32'hffffffff);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  task t_lit_or();
    exe(12'hc00, 8'h00);
    chk({acc_value, zero_flag}, 9'h000, "literal zero");
    exe(12'hca5, 8'h00);
    chk(acc_value, 8'ha5, "literal");
    gap(D);
    exe(12'h103, 8'h18);
    chk({acc_value, zero_flag}, {8'hbd, 1'b0}, "or to acc");
    exe(12'hc00, 8'h00);
    exe(12'h11f, 8'h00);
    chk({acc_value, zero_flag}, 9'h001, "or zero");
    exe(12'h13f, 8'h0f);
    chk({file_we, file_waddr, file_wdata}, {1'b1, 5'h1f, 8'h0f}, "or to file");
    chk({acc_value, zero_flag}, 9'h000, "or to file acc");
    $display("test literal and or done");
  endtask

  task t_move();
    exe(12'h205, 8'h00);
    chk({acc_value, zero_flag}, 9'h001, "move zero");
    exe(12'hc3c, 8'h00);
    chk({acc_value, zero_flag}, {8'h3c, 1'b1}, "literal keeps z");
    exe(12'h027, 8'h00);
    chk({file_we, file_waddr, file_wdata, zero_flag}, {1'b1, 5'h07, 8'h3c, 1'b1}, "store");
    exe(12'h229, 8'h44);
    chk({file_we, file_waddr, file_wdata, zero_flag}, {1'b1, 5'h09, 8'h44, 1'b0}, "move f");
    chk(acc_value, 8'h3c, "move f acc");
    exe(12'h000, 8'hff);
    chk({file_we, option_we, acc_value, zero_flag}, {2'b00, 8'h3c, 1'b0}, "nop");
    gap(D);
    exe(12'h002, 8'h00);
    chk({option_we, option_value, zero_flag}, {1'b1, 8'h3c, 1'b0}, "option");
    $display("test move, nop and option done");
  endtask

  task t_ret_sleep();
    int i;
    int hits;
    hits = 0;
    exe(12'h877, 8'h00, 9'h155);
    chk({stack_pop, acc_value, zero_flag}, {1'b1, 8'h77, 1'b0}, "return");
    gap(2 * D);
    ahb(1'b1, REG_STATUS, 32'h88);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h88, "status write");
    exe(12'h003, 8'h00);
    chk(watchdog_counter_clear, 1'b1, "watchdog clear");
    chk({timeout_status_bit, powerdown_status_bit}, 2'b10, "sleep status");
    chk(pin_change_wake_flag, 1'b1, "wake flag");
    chk(sleep_mode, 1'b1, "asleep");
    for (i = 0; i < 4 * D; i++) begin
      @(negedge core_clk);
      if (instr_ready !== 1'b0) hits++;
    end
    chk(hits, 0, "ready while asleep");
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h94, "status asleep");
    ahb(1'b1, REG_CTRL, 32'h3);
    exe(12'hc11, 8'h00);
    chk(sleep_mode, 1'b0, "woken");
    ahb(1'b0, REG_ACC, 32'h0);
    chk(rd, 32'h11, "acc read");
    $display("test return and sleep done");
  endtask

  task t_ctrl();
    int i;
    int hits;
    hits = 0;
    exe(12'hf00, 8'h00);
    chk(acc_value, 8'h11, "illegal keeps acc");
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h92, "illegal set");
    ahb(1'b1, REG_STATUS, 32'h12);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h10, "illegal cleared");
    ahb(1'b1, REG_CTRL, 32'h0);
    for (i = 0; i < 4 * D; i++) begin
      @(negedge core_clk);
      if (instr_ready !== 1'b0) hits++;
    end
    chk(hits, 0, "ready while held");
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl read");
    ahb(1'b1, REG_CTRL, 32'h1);
    exe(12'hc5a, 8'h00);
    chk(acc_value, 8'h5a, "resumed");
    $display("test control and illegal code done");
  endtask

  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, instr_valid} = 3'b000;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    instr = 12'h000;
    file_rdata = 8'h00;
    stack_top = 9'h000;
    pc_e = 9'h000;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_lit_or();
    t_move();
    t_ret_sleep();
    t_ctrl();
    results();
  end

  initial begin
    #200000;
    hang();
  end
endmodule

// File: inc/mrsx_pkg.sv
package mrsx_pkg;

  localparam int DATA_W  = 8;
  localparam int FADDR_W = 5;
  localparam int INSTR_W = 12;
  localparam int PC_W    = 9;
  localparam int CYC_DIV = 4;

  // Twelve-bit instruction words: a pattern and the mask of its fixed bits.
  localparam logic [11:0] OPC_NOP        = 12'h000;
  localparam logic [11:0] OPC_OPTION     = 12'h002;
  localparam logic [11:0] OPC_SLEEP      = 12'h003;
  localparam logic [11:0] MSK_EXACT      = 12'hfff;
  localparam logic [11:0] OPC_STORE_ACC  = 12'h020;
  localparam logic [11:0] MSK_STORE_ACC  = 12'hfe0;
  localparam logic [11:0] OPC_OR_FILE    = 12'h100;
  localparam logic [11:0] OPC_MOVE_FILE  = 12'h200;
  localparam logic [11:0] MSK_FILE_DEST  = 12'hfc0;
  localparam logic [11:0] OPC_RET_LIT    = 12'h800;
  localparam logic [11:0] OPC_LOAD_LIT   = 12'hc00;
  localparam logic [11:0] MSK_LITERAL    = 12'hf00;
  localparam int          DEST_BIT       = 5;

  // Register map, byte addresses on the bus.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC    = 8'h08;
  localparam logic [7:0] REG_OPTION = 8'h0c;
  localparam logic [7:0] REG_PC     = 8'h10;

  localparam int CTRL_EXEC_EN = 0;
  localparam int CTRL_WAKE    = 1;
  localparam int ST_ZERO      = 0;
  localparam int ST_ILLEGAL   = 1;
  localparam int ST_SLEEPING  = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_TIMEOUT   = 4;
  localparam int ST_WAKE_FLAG = 7;

  localparam logic [7:0] RST_OPTION  = 8'hff;
  localparam logic [7:0] RST_ACC     = 8'h00;
  localparam logic       RST_EXEC_EN = 1'b1;

  typedef enum logic [3:0] {
    OP_NOP, OP_OPTION, OP_SLEEP, OP_STORE_ACC, OP_OR_FILE,
    OP_MOVE_FILE, OP_RET_LIT, OP_LOAD_LIT, OP_ILLEGAL
  } mrsx_op_e;

  typedef enum logic [2:0] {
    S_RUN   = 3'b001,
    S_RET2  = 3'b010,
    S_SLEEP = 3'b100
  } mrsx_state_e;

  function automatic logic opc_hit(logic [11:0] w, logic [11:0] p, logic [11:0] m);
    return (w & m) == p;
  endfunction

  function automatic mrsx_op_e mrsx_decode(logic [11:0] w);
    if (opc_hit(w, OPC_NOP, MSK_EXACT))             return OP_NOP;
    if (opc_hit(w, OPC_OPTION, MSK_EXACT))          return OP_OPTION;
    if (opc_hit(w, OPC_SLEEP, MSK_EXACT))           return OP_SLEEP;
    if (opc_hit(w, OPC_STORE_ACC, MSK_STORE_ACC))   return OP_STORE_ACC;
    if (opc_hit(w, OPC_OR_FILE, MSK_FILE_DEST))     return OP_OR_FILE;
    if (opc_hit(w, OPC_MOVE_FILE, MSK_FILE_DEST))   return OP_MOVE_FILE;
    if (opc_hit(w, OPC_RET_LIT, MSK_LITERAL))       return OP_RET_LIT;
    if (opc_hit(w, OPC_LOAD_LIT, MSK_LITERAL))      return OP_LOAD_LIT;
    return OP_ILLEGAL;
  endfunction

endpackage

// File: logic/mrsx_ahb.sv
`timescale 1ns/1ps
module mrsx_ahb
  import mrsx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata
);
  import mrsx_pkg::*;

  typedef struct packed {
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
  } mrsx_ahb_s;

  mrsx_ahb_s q;
  mrsx_ahb_s next_q;
  logic      take;

  // Read data is captured at the address phase, so the data phase needs no wait.
  always_comb begin
    take      = hsel && htrans[1] && hready;
    rd_addr   = haddr[7:0];
    next_q    = q;
    next_q.dp_wr = take && hwrite;
    if (take) begin
      next_q.dp_addr = haddr[7:0];
      next_q.rdata   = hwrite ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign reg_wr    = q.dp_wr;
  assign reg_addr  = q.dp_addr;
  assign reg_wdata = hwdata;

endmodule

// File: logic/mrsx_alu.sv
`timescale 1ns/1ps
module mrsx_alu
  import mrsx_pkg::*;
(
  input  wire logic [mrsx_pkg::INSTR_W-1:0] instr,
  input  wire logic [mrsx_pkg::DATA_W-1:0]  acc,
  input  wire logic [mrsx_pkg::DATA_W-1:0]  file_rdata,
  output mrsx_pkg::mrsx_op_e                op,
  output logic      [mrsx_pkg::DATA_W-1:0]  result,
  output logic                              zero,
  output logic                              to_file
);
  import mrsx_pkg::*;

  always_comb begin
    op = mrsx_decode(instr);
    case (op)
      OP_OR_FILE:   result = acc | file_rdata;
      OP_MOVE_FILE: result = file_rdata;
      OP_STORE_ACC: result = acc;
      OP_LOAD_LIT,
      OP_RET_LIT:   result = instr[DATA_W-1:0];
      default:      result = acc;
    endcase
    zero    = (result == '0);
    to_file = (op == OP_STORE_ACC) ||
              (((op == OP_OR_FILE) || (op == OP_MOVE_FILE)) && instr[DEST_BIT]);
  end

endmodule

// File: logic/mrsx_exec.sv
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// What this block does
// - OR accumulator with file register, write selected destination, update zero flag.
// - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// - Store accumulator into file register without touching any status flag.
// - Move file register to destination and update zero flag.
// - No-operation changes no register, memory or flag.
// - Load eight-bit literal into accumulator, flags unchanged.
// - Copy accumulator into the timer option register, flags unchanged.
// - Return loads literal into accumulator and program counter from stack top.
// - Return takes two instruction cycles.
// - Sleep clears the watchdog counter with a one-cycle watchdog_counter_clear pulse.
// - Sleep sets timeout status bit and clears powerdown status bit.
// - Sleep leaves the pin change wake flag as it was.
// - Sleep then halts the processor with its oscillator stopped.
module mrsx_exec
  import mrsx_pkg::*;
#(
  parameter int CYC_DIV_P = mrsx_pkg::CYC_DIV
)(
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  input  wire logic                         instr_valid,
  output logic                              instr_ready,
  input  wire logic [mrsx_pkg::INSTR_W-1:0] instr,
  input  wire logic [mrsx_pkg::DATA_W-1:0]  file_rdata,
  input  wire logic [mrsx_pkg::PC_W-1:0]    stack_top,
  output logic                              stack_pop,
  output logic                              file_we,
  output logic [mrsx_pkg::FADDR_W-1:0]      file_waddr,
  output logic [mrsx_pkg::DATA_W-1:0]       file_wdata,
  output logic                              option_we,
  output logic [mrsx_pkg::DATA_W-1:0]       option_value,
  output logic [mrsx_pkg::DATA_W-1:0]       acc_value,
  output logic [mrsx_pkg::PC_W-1:0]         pc,
  output logic                              zero_flag,
  output logic                              timeout_status_bit,
  output logic                              powerdown_status_bit,
  output logic                              pin_change_wake_flag,
  output logic                              watchdog_counter_clear,
  output logic                              sleep_mode
);
  import mrsx_pkg::*;

  localparam int DIV_W = $clog2(CYC_DIV_P + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_DIV_P - 1);
  // Power-on state of the two reset-status bits.
  localparam logic             RST_TIMEOUT   = 1'b1;
  localparam logic             RST_POWERDOWN = 1'b1;

  typedef struct packed {
    mrsx_state_e            st;
    logic [DIV_W-1:0]       div;
    logic [DATA_W-1:0]      acc;
    logic [DATA_W-1:0]      option;
    logic [PC_W-1:0]        pc;
    logic                   z;
    logic                   timeout;
    logic                   powerdown;
    logic                   wake_flag;
    logic                   illegal;
    logic                   exec_en;
    logic                   fwe;
    logic [FADDR_W-1:0]     fwaddr;
    logic [DATA_W-1:0]      fwdata;
    logic                   opt_we;
    logic                   wdog_clr;
    logic                   pop;
  } mrsx_exec_s;

  // Whole-state reset image, so the reset branch assigns one constant.
  localparam mrsx_exec_s RST_Q = '{
    st:        S_RUN,
    div:       '0,
    acc:       RST_ACC,
    option:    RST_OPTION,
    pc:        '0,
    z:         1'b0,
    timeout:   RST_TIMEOUT,
    powerdown: RST_POWERDOWN,
    wake_flag: 1'b0,
    illegal:   1'b0,
    exec_en:   RST_EXEC_EN,
    fwe:       1'b0,
    fwaddr:    '0,
    fwdata:    '0,
    opt_we:    1'b0,
    wdog_clr:  1'b0,
    pop:       1'b0
  };

  mrsx_exec_s         q;
  mrsx_exec_s         next_q;
  logic               tick;
  logic               accept;
  mrsx_op_e           op;
  logic [DATA_W-1:0]  result;
  logic               zero;
  logic               to_file;
  logic [7:0]         rd_addr;
  logic [31:0]        rd_data;
  logic               reg_wr;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;

  mrsx_alu u_alu (
    .instr      (instr),
    .acc        (q.acc),
    .file_rdata (file_rdata),
    .op         (op),
    .result     (result),
    .zero       (zero),
    .to_file    (to_file)
  );

  mrsx_ahb u_ahb (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata)
  );

  // State test shared by the divider, the wake path and the status word.
  function automatic logic asleep(mrsx_state_e s);
    return s == S_SLEEP;
  endfunction

  function automatic logic [31:0] status_word(mrsx_exec_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_ZERO]      = s.z;
    w[ST_ILLEGAL]   = s.illegal;
    w[ST_SLEEPING]  = asleep(s.st);
    w[ST_POWERDOWN] = s.powerdown;
    w[ST_TIMEOUT]   = s.timeout;
    w[ST_WAKE_FLAG] = s.wake_flag;
    return w;
  endfunction

  // Unmapped offsets read as zero; writes to them are dropped.
  always_comb begin
    case (rd_addr)
      REG_CTRL:   rd_data = {31'h0000_0000, q.exec_en};
      REG_STATUS: rd_data = status_word(q);
      REG_ACC:    rd_data = {24'h00_0000, q.acc};
      REG_OPTION: rd_data = {24'h00_0000, q.option};
      REG_PC:     rd_data = {{(32 - PC_W){1'b0}}, q.pc};
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  // The divider stands still in sleep, which models the stopped oscillator.
  assign tick        = !asleep(q.st) && (q.div == DIV_LAST);
  // Ready is offered once per instruction cycle, and only while running.
  assign instr_ready = tick && (q.st == S_RUN) && q.exec_en;
  assign accept      = instr_ready && instr_valid;

  always_comb begin
    next_q          = q;
    // Pulse outputs fall back to zero unless this cycle raises them.
    next_q.fwe      = 1'b0;
    next_q.opt_we   = 1'b0;
    next_q.wdog_clr = 1'b0;
    next_q.pop      = 1'b0;

    if (!asleep(q.st)) begin
      next_q.div = tick ? '0 : q.div + DIV_W'(1);
    end

    // Software writes come first so that an instruction event in the same
    // cycle wins over a software clear.
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          next_q.exec_en = reg_wdata[CTRL_EXEC_EN];
          if (reg_wdata[CTRL_WAKE] && asleep(q.st)) begin
            next_q.st  = S_RUN;
            next_q.div = '0;
          end
        end
        REG_STATUS: begin
          next_q.wake_flag = reg_wdata[ST_WAKE_FLAG];
          // Watchdog and power events live outside; software stands in for them.
          next_q.timeout   = reg_wdata[ST_TIMEOUT];
          next_q.powerdown = reg_wdata[ST_POWERDOWN];
          if (reg_wdata[ST_ILLEGAL]) begin
            next_q.illegal = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (q.st)
      S_RUN: begin
        if (accept) begin
          next_q.pc = q.pc + PC_W'(1);
          case (op)
            OP_NOP: begin
            end
            OP_OPTION: begin
              next_q.option = q.acc;
              next_q.opt_we = 1'b1;
            end
            // Sleep still advances the pc, so a wake resumes at the next word.
            OP_SLEEP: begin
              next_q.wdog_clr  = 1'b1;
              next_q.timeout   = 1'b1;
              next_q.powerdown = 1'b0;
              next_q.st        = S_SLEEP;
            end
            OP_STORE_ACC,
            OP_OR_FILE,
            OP_MOVE_FILE: begin
              if (to_file) begin
                next_q.fwe    = 1'b1;
                next_q.fwaddr = instr[FADDR_W-1:0];
                next_q.fwdata = result;
              end else begin
                next_q.acc = result;
              end
              // Store-acc leaves the zero flag; the other two always update it.
              if (op != OP_STORE_ACC) begin
                next_q.z = zero;
              end
            end
            OP_LOAD_LIT: begin
              next_q.acc = result;
            end
            OP_RET_LIT: begin
              next_q.acc = result;
              next_q.pc  = stack_top;
              next_q.pop = 1'b1;
              next_q.st  = S_RET2;
            end
            // Codes outside this set act as a no-op that raises the sticky flag.
            default: begin
              next_q.illegal = 1'b1;
            end
          endcase
        end
      end
      // The tick after a return is swallowed, giving it two instruction cycles.
      S_RET2: begin
        if (tick) begin
          next_q.st = S_RUN;
        end
      end
      S_SLEEP: begin
      end
      default: begin
        next_q.st = S_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_Q;
    end else begin
      q <= next_q;
    end
  end

  assign stack_pop              = q.pop;
  assign file_we                = q.fwe;
  assign file_waddr             = q.fwaddr;
  assign file_wdata             = q.fwdata;
  assign option_we              = q.opt_we;
  assign option_value           = q.option;
  assign acc_value              = q.acc;
  assign pc                     = q.pc;
  assign zero_flag              = q.z;
  assign timeout_status_bit     = q.timeout;
  assign powerdown_status_bit   = q.powerdown;
  assign pin_change_wake_flag   = q.wake_flag;
  assign watchdog_counter_clear = q.wdog_clr;
  assign sleep_mode             = asleep(q.st);

endmodule
